// ===== tb/rtcwk_top_bench.sv
// register-level bench for the seconds and wake-up timer block
`timescale 1ns/1ps
`include "rtcwk_consts.svh"
module rtcwk_top_bench;
  import rtcwk_pkg::*;
  // short counts keep the run brief; expectations follow them
  localparam int unsigned SEC = 20;
  localparam int unsigned MS  = 4;
  localparam logic [31:0] SWRST = 32'h1 << `RTCWK_CTRL_SWRST;
  localparam logic [31:0] EN    = 32'h1 << `RTCWK_CTRL_EN;
  localparam logic [31:0] WKEN  = 32'h1 << `RTCWK_CTRL_WKEN;
  localparam logic [31:0] ALDPD = 32'h1 << `RTCWK_CTRL_ALDPD;
  localparam logic [31:0] WKDPD = 32'h1 << `RTCWK_CTRL_WKDPD;

  logic             clk;
  logic             srst;
  rtcwk_req_t       req;
  logic [31:0]      rdata;
  logic             irq;
  logic             dpd_wake;
  logic [31:0]      v;
  logic [31:0]      v2;
  int               failures;
  int               checks;

  rtcwk_top #(.SEC_CYC(SEC), .MS_CYC(MS), .WAKE_W(16)) i_rtcwk_top (
    .clk                  (clk),
    .srst                 (srst),
    .req                  (req),
    .rdata                (rdata),
    .irq                  (irq),
    .deep_power_down_wake (dpd_wake)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // strobes last one cycle, then a quiet cycle before the next access
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // look mid-cycle, then hand back on a rising edge for the next drive
  task automatic pins(input logic ei, input logic ed);
    @(negedge clk);
    chk("irq", {31'h0, irq}, {31'h0, ei});
    chk("dpd_wake", {31'h0, dpd_wake}, {31'h0, ed});
    @(posedge clk);
  endtask

  initial begin
    failures = 0;
    checks = 0;
    srst = 1'b1;
    req = '0;
    idle(16);
    srst <= 1'b0;
    @(posedge clk);
    // reset state and readback
    rd(`RTCWK_OFF_MATCH, v); chk("match", v, `RTCWK_MATCH_RST);
    rd(`RTCWK_OFF_CTRL, v); chk("ctrl", v, 32'h0);
    rd(4'hf, v); chk("unmapped", v, 32'h0);
    pins(1'b0, 1'b0);
    // loading while stopped, ignored while running, 1 Hz advance
    wr(`RTCWK_OFF_COUNT, 32'ha);
    rd(`RTCWK_OFF_COUNT, v); chk("count load", v, 32'ha);
    wr(`RTCWK_OFF_CTRL, EN);
    wr(`RTCWK_OFF_COUNT, 32'h63);
    idle(5 * SEC + 4);
    wr(`RTCWK_OFF_CTRL, 32'h0);
    rd(`RTCWK_OFF_COUNT, v); chk("count run", v, 32'hf);
    // alarm match, mask and power-down wake
    wr(`RTCWK_OFF_COUNT, 32'h0);
    wr(`RTCWK_OFF_MATCH, 32'h3);
    wr(`RTCWK_OFF_MASK, 32'h1);
    wr(`RTCWK_OFF_CTRL, EN | ALDPD);
    idle(2 * SEC + 5);
    pins(1'b0, 1'b0);
    idle(SEC);
    pins(1'b1, 1'b1);
    rd(`RTCWK_OFF_STATUS, v); chk("alarm flag", v, 32'h1);
    rd(`RTCWK_OFF_MATCH, v); chk("match rb", v, 32'h3);
    wr(`RTCWK_OFF_MASK, 32'h0);
    pins(1'b0, 1'b1);
    wr(`RTCWK_OFF_MASK, 32'h1);
    pins(1'b1, 1'b1);
    wr(`RTCWK_OFF_STATUS, 32'h1);
    pins(1'b0, 1'b0);
    wr(`RTCWK_OFF_CTRL, 32'h0);
    // wake load enables the countdown but the master enable gates it
    wr(`RTCWK_OFF_WAKE, 32'h5);
    rd(`RTCWK_OFF_CTRL, v); chk("wake en", v, WKEN);
    idle(8 * MS);
    rd(`RTCWK_OFF_WAKE, v);
    rd(`RTCWK_OFF_WAKE, v2);
    chk("wake twice", v2, v);
    chk("wake held", v, 32'h5);
    wr(`RTCWK_OFF_MASK, 32'h2);
    wr(`RTCWK_OFF_CTRL, EN | WKEN | WKDPD);
    idle(2 * MS);
    pins(1'b0, 1'b0);
    idle(5 * MS);
    pins(1'b1, 1'b1);
    rd(`RTCWK_OFF_WAKE, v); chk("wake zero", v, 32'h0);
    rd(`RTCWK_OFF_STATUS, v); chk("wake flag", v, 32'h2);
    // software reset holds everything until written back to zero
    wr(`RTCWK_OFF_CTRL, SWRST);
    wr(`RTCWK_OFF_WAKE, 32'h7);
    rd(`RTCWK_OFF_CTRL, v); chk("swrst held", v, SWRST);
    rd(`RTCWK_OFF_MATCH, v); chk("swrst match", v, `RTCWK_MATCH_RST);
    rd(`RTCWK_OFF_WAKE, v); chk("swrst wake", v, 32'h0);
    pins(1'b0, 1'b0);
    wr(`RTCWK_OFF_CTRL, 32'h0);
    rd(`RTCWK_OFF_CTRL, v); chk("swrst off", v, 32'h0);
    print_verdict();
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    idle(5000);
    failures++;
    print_verdict();
  end
endmodule

// ===== verilog/rtcwk_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef RTCWK_CONSTS_SVH
`define RTCWK_CONSTS_SVH
`define RTCWK_ADDR_W        4
`define RTCWK_OFF_CTRL      4'h0
`define RTCWK_OFF_MATCH     4'h1
`define RTCWK_OFF_COUNT     4'h2
`define RTCWK_OFF_WAKE      4'h3
`define RTCWK_OFF_STATUS    4'h4
`define RTCWK_OFF_MASK      4'h5
`define RTCWK_CTRL_SWRST    0
`define RTCWK_CTRL_EN       1
`define RTCWK_CTRL_WKEN     2
`define RTCWK_CTRL_ALDPD    3
`define RTCWK_CTRL_WKDPD    4
`define RTCWK_ST_ALARM      0
`define RTCWK_ST_WAKE       1
`define RTCWK_CLK_HZ        200000000
`define RTCWK_SEC_HZ        1
`define RTCWK_MS_HZ         1000
`define RTCWK_SEC_CYC       (`RTCWK_CLK_HZ / `RTCWK_SEC_HZ)
`define RTCWK_MS_CYC        (`RTCWK_CLK_HZ / `RTCWK_MS_HZ)
`define RTCWK_MATCH_RST     32'hffff_ffff
`endif

// ===== verilog/rtcwk_pkg.sv
// shared types for the seconds and wake-up timer block
package rtcwk_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } rtcwk_req_t;
  typedef enum logic [1:0] {
    RTCWK_WK_IDLE = 2'b00,
    RTCWK_WK_RUN  = 2'b01,
    RTCWK_WK_DONE = 2'b10
  } rtcwk_wk_t;
endpackage

// ===== verilog/rtcwk_tick.sv
// run-gated divider giving one-cycle ticks
`timescale 1ns/1ps
module rtcwk_tick #(
  parameter int unsigned DIV = 1000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // gating and tick
  input  wire logic run,
  output logic      tick
);
  logic [31:0] cnt_r;
  // divider restarts whenever run drops, so first tick is a full period
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule

// ===== verilog/rtcwk_top.sv
// seconds counter, alarm, wake-up countdown and register port
//
// What this block does
// - seconds count advances on 1 Hz tick
// - wake countdown decrements on 1 kHz tick
// - master enable gates both ticks; wake expiry at a zero count is not gated
// - count writes ignored while counter runs
// - writing wake count loads and enables it
// - alarm and wake flags, cleared by software
// - wake event enable for power-down wake
// - alarm event enable for power-down wake
// - reset bit clears registers, stays until cleared
// - match and live count always readable
`timescale 1ns/1ps
`include "rtcwk_consts.svh"
module rtcwk_top
  import rtcwk_pkg::*;
#(
  parameter int unsigned SEC_CYC = `RTCWK_SEC_CYC,
  parameter int unsigned MS_CYC  = `RTCWK_MS_CYC,
  parameter int          WAKE_W  = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire rtcwk_pkg::rtcwk_req_t req,
  output logic [31:0]      rdata,
  // events
  output logic             irq,
  output logic             deep_power_down_wake
);
  import rtcwk_pkg::*;

  logic              en_r, wken_r, swrst_r;
  logic              alarm_irq_enable_r, wakeup_irq_enable_r;
  logic [31:0]       match_r, count_r;
  logic [1:0]        status_r, mask_r;
  logic              sec_tick, ms_tick;
  logic [WAKE_W-1:0] wk_count;
  logic              wk_active, wk_hit, wk_load;
  logic              alarm_flag, wakeup_flag;
  logic              blk_rst;
  logic              alarm_ev;

  // software reset bit holds every other register at reset except irq, deep_power_down_wake and rdata
  assign blk_rst = srst | swrst_r;
  assign wk_load = req.wr && req.addr == `RTCWK_OFF_WAKE && !swrst_r;

  rtcwk_tick #(.DIV(SEC_CYC)) u_sec (
    .clk  (clk),
    .srst (blk_rst),
    .run  (en_r),
    .tick (sec_tick)
  );

  rtcwk_tick #(.DIV(MS_CYC)) u_ms (
    .clk  (clk),
    .srst (blk_rst),
    .run  (en_r && wken_r),
    .tick (ms_tick)
  );

  rtcwk_wake #(.W(WAKE_W)) u_wake (
    .clk      (clk),
    .srst     (blk_rst),
    .load     (wk_load),
    .load_val (req.wdata[WAKE_W-1:0]),
    .run      (en_r && wken_r),
    .ms_tick  (ms_tick),
    .count    (wk_count),
    .active   (wk_active),
    .hit      (wk_hit)
  );

  // the reset bit itself only yields to srst or a write of zero
  always_ff @(posedge clk) begin
    if (srst) begin
      swrst_r <= 1'b0;
    end else if (req.wr && req.addr == `RTCWK_OFF_CTRL) begin
      swrst_r <= req.wdata[`RTCWK_CTRL_SWRST];
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      en_r                <= 1'b0;
      alarm_irq_enable_r  <= 1'b0;
      wakeup_irq_enable_r <= 1'b0;
    end else if (req.wr && req.addr == `RTCWK_OFF_CTRL) begin
      en_r                <= req.wdata[`RTCWK_CTRL_EN];
      alarm_irq_enable_r  <= req.wdata[`RTCWK_CTRL_ALDPD];
      wakeup_irq_enable_r <= req.wdata[`RTCWK_CTRL_WKDPD];
    end
  end

  // wake enable is also set by a load of the countdown
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      wken_r <= 1'b0;
    end else if (wk_load) begin
      wken_r <= 1'b1;
    end else if (req.wr && req.addr == `RTCWK_OFF_CTRL) begin
      wken_r <= req.wdata[`RTCWK_CTRL_WKEN];
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      match_r <= `RTCWK_MATCH_RST;
    end else if (req.wr && req.addr == `RTCWK_OFF_MATCH) begin
      match_r <= req.wdata;
    end
  end

  // writes while running are dropped silently
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      count_r <= 32'h0;
    end else if (req.wr && req.addr == `RTCWK_OFF_COUNT && !en_r) begin
      count_r <= req.wdata;
    end else if (en_r && sec_tick) begin
      count_r <= count_r + 32'h1;
    end
  end

  // compare on the incremented count so only an advance onto the match fires, not a loaded equal value
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      alarm_ev <= 1'b0;
    end else begin
      alarm_ev <= en_r && sec_tick && (count_r + 32'h1 == match_r);
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      status_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `RTCWK_ST_ALARM) ? alarm_ev : wk_hit) begin
          status_r[i] <= 1'b1;
        end else if (req.wr && req.addr == `RTCWK_OFF_STATUS &&
                     req.wdata[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      mask_r <= 2'b00;
    end else if (req.wr && req.addr == `RTCWK_OFF_MASK) begin
      mask_r <= req.wdata[1:0];
    end
  end

  assign alarm_flag  = status_r[`RTCWK_ST_ALARM];
  assign wakeup_flag = status_r[`RTCWK_ST_WAKE];

  always_ff @(posedge clk) begin
    if (srst) begin
      irq                  <= 1'b0;
      deep_power_down_wake <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
      deep_power_down_wake <= (alarm_flag && alarm_irq_enable_r) ||
                              (wakeup_flag && wakeup_irq_enable_r);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst || !req.rd) begin
      rdata <= 32'h0;
    end else begin
      unique case (req.addr)
        `RTCWK_OFF_CTRL: begin
          rdata <= 32'h0;
          rdata[`RTCWK_CTRL_SWRST] <= swrst_r;
          rdata[`RTCWK_CTRL_EN]    <= en_r;
          rdata[`RTCWK_CTRL_WKEN]  <= wken_r;
          rdata[`RTCWK_CTRL_ALDPD] <= alarm_irq_enable_r;
          rdata[`RTCWK_CTRL_WKDPD] <= wakeup_irq_enable_r;
        end
        `RTCWK_OFF_MATCH:  rdata <= match_r;
        `RTCWK_OFF_COUNT:  rdata <= count_r;
        // may move mid-access, software double-reads
        `RTCWK_OFF_WAKE:   rdata <= {{(32-WAKE_W){1'b0}}, wk_count};
        `RTCWK_OFF_STATUS: rdata <= {30'h0, status_r};
        `RTCWK_OFF_MASK:   rdata <= {30'h0, mask_r};
        default:           rdata <= 32'h0;
      endcase
    end
  end

  // checks

  // helper gap counters: edges since last tick or restart
  logic [31:0] sec_gap_r;
  logic [31:0] ms_gap_r;

  always_ff @(posedge clk) begin
    if (blk_rst || !en_r) begin
      sec_gap_r <= 32'h0;
    end else if (sec_tick) begin
      sec_gap_r <= 32'h1;
    end else begin
      sec_gap_r <= sec_gap_r + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst || !(en_r && wken_r)) begin
      ms_gap_r <= 32'h0;
    end else if (ms_tick) begin
      ms_gap_r <= 32'h1;
    end else begin
      ms_gap_r <= ms_gap_r + 32'h1;
    end
  end

  // alarm path: matching tick, one-cycle event, sticky flag
  sequence s_alarm_tick;
    en_r && sec_tick && count_r + 32'h1 == match_r;
  endsequence

  sequence s_alarm_raise;
    alarm_ev ##1 alarm_flag;
  endsequence

  // wake path: hit pulse, then sticky flag
  sequence s_wake_raise;
    wk_hit ##1 wakeup_flag;
  endsequence

  // soft reset clears the count too, so blk_rst disables this
  property p_wake_gated;
    @(posedge clk) disable iff (blk_rst)
      !en_r |=> $stable(wk_count) || $past(wk_load);
  endproperty
  wake_gated_a: assert property (p_wake_gated)
    else $error("wake count moved with master enable clear");

  count_locked_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    en_r && !sec_tick |=> count_r == $past(count_r))
    else $error("seconds count changed without tick");

  sec_step_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    en_r && sec_tick |=> count_r == $past(count_r) + 32'h1)
    else $error("seconds count did not advance");

  sec_period_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    sec_tick |-> sec_gap_r == SEC_CYC)
    else $error("seconds tick period wrong");

  ms_period_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    ms_tick |-> ms_gap_r == MS_CYC)
    else $error("millisecond tick period wrong");

  sec_gated_a: assert property (
    @(posedge clk) disable iff (srst)
    !en_r |=> !sec_tick)
    else $error("seconds tick with master enable clear");

  ms_gated_a: assert property (
    @(posedge clk) disable iff (srst)
    !en_r |=> !ms_tick)
    else $error("millisecond tick with master enable clear");

  count_load_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    req.wr && req.addr == `RTCWK_OFF_COUNT && !en_r
      |=> count_r == $past(req.wdata))
    else $error("count write while stopped lost");

  wake_load_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    wk_load |=> wken_r && wk_active)
    else $error("wake load did not enable timer");

  alarm_set_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    s_alarm_tick |=> s_alarm_raise)
    else $error("alarm flag missing on match");

  wake_zero_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    wk_active && wk_count == '0 && !wk_load |=> s_wake_raise)
    else $error("wake countdown at zero raised no flag");

  wake_done_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    wk_hit |=> wakeup_flag)
    else $error("wake flag missing at zero");

  wake_stop_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    wk_hit |-> !wk_active && wk_count == '0)
    else $error("wake countdown did not stop at zero");

  swrst_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    swrst_r && !(req.wr && req.addr == `RTCWK_OFF_CTRL) |=>
      swrst_r && !en_r && status_r == 2'b00)
    else $error("soft reset not held");

  swrst_wake_a: assert property (
    @(posedge clk) disable iff (srst)
    swrst_r |=> !wk_active && wk_count == '0)
    else $error("soft reset left wake countdown alive");

  dpd_wake_a: assert property (
    @(posedge clk) disable iff (srst)
    wakeup_flag && wakeup_irq_enable_r |=> deep_power_down_wake)
    else $error("wake did not raise power-down wake");

  dpd_alarm_a: assert property (
    @(posedge clk) disable iff (srst)
    alarm_flag && alarm_irq_enable_r |=> deep_power_down_wake)
    else $error("alarm did not raise power-down wake");

  dpd_quiet_a: assert property (
    @(posedge clk) disable iff (srst)
    !alarm_flag && !wakeup_flag |=> !deep_power_down_wake)
    else $error("power-down wake without a flag");

  flag_clear_a: assert property (
    @(posedge clk) disable iff (blk_rst)
    req.wr && req.addr == `RTCWK_OFF_STATUS && req.wdata[0] && !alarm_ev
      |=> !alarm_flag)
    else $error("alarm flag not cleared");

  irq_level_a: assert property (
    @(posedge clk) disable iff (srst)
    (status_r & mask_r) != 2'b00 |=> irq)
    else $error("unmasked flag raised no interrupt");

  irq_mask_a: assert property (
    @(posedge clk) disable iff (srst)
    (status_r & mask_r) == 2'b00 |=> !irq)
    else $error("interrupt without unmasked flag");

  count_read_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && req.addr == `RTCWK_OFF_COUNT |=> rdata == $past(count_r))
    else $error("count readback wrong");

  match_read_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && req.addr == `RTCWK_OFF_MATCH |=> rdata == $past(match_r))
    else $error("match readback wrong");
endmodule

// ===== verilog/rtcwk_wake.sv
// millisecond wake-up countdown
`timescale 1ns/1ps
`include "rtcwk_consts.svh"
module rtcwk_wake
  import rtcwk_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  input  wire logic         ms_tick,
  // status
  output logic [W-1:0]      count,
  output logic              active,
  output logic              hit
);
  rtcwk_wk_t st_r;
  always_ff @(posedge clk) begin
    hit <= 1'b0;
    if (srst) begin
      st_r  <= RTCWK_WK_IDLE;
      count <= '0;
    end else if (load) begin
      st_r  <= RTCWK_WK_RUN;
      count <= load_val;
    end else begin
      unique case (st_r)
        RTCWK_WK_IDLE: st_r <= RTCWK_WK_IDLE;
        RTCWK_WK_RUN: begin
          if (count == '0) begin
            st_r <= RTCWK_WK_DONE;
            hit  <= 1'b1;
          end else if (run && ms_tick) begin
            count <= count - 1'b1;
          end
        end
        RTCWK_WK_DONE: st_r <= RTCWK_WK_DONE;
        default:       st_r <= RTCWK_WK_IDLE;
      endcase
    end
  end
  assign active = (st_r == RTCWK_WK_RUN);
endmodule
